// ==== rtl/lsi_pkg.sv ====
// Package for the line status and interrupt event register block.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
package lsi_pkg;

    // ------------------------------------------------------------------
    // Register indices as printed; byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] LSI_IDX_LIVE_A  = 8'h17;
    localparam logic [7:0] LSI_IDX_LIVE_B  = 8'h18;
    localparam logic [7:0] LSI_IDX_LATCH_A = 8'h19;
    localparam logic [7:0] LSI_IDX_LATCH_B = 8'h1a;
    localparam logic [7:0] LSI_IDX_CTRL    = 8'h20;

    // Address width of the register bus.
    localparam int LSI_AW = 12;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int LSI_BIT_LOS   = 0;
    localparam int LSI_BIT_AIS   = 1;
    localparam int LSI_BIT_DF    = 2;
    localparam int LSI_BIT_TCLK  = 3;
    localparam int LSI_BIT_PRBS  = 4;
    localparam int LSI_BIT_LPDN  = 5;
    localparam int LSI_BIT_LPUP  = 6;
    localparam int LSI_BIT_RLP   = 5;

    // Control register: masks in bits 2..0, edge selects in bits 6..4.
    localparam int LSI_CTRL_ES_SHIFT = 4;
    localparam logic [7:0] LSI_CTRL_RESET = 8'h07;
    localparam logic [7:0] LSI_CTRL_WMASK = 8'h77;

    // AXI response codes.
    localparam logic [1:0] LSI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LSI_RESP_SLVERR = 2'h2;

    // Live condition inputs grouped together.
    typedef struct packed {
        logic driver_short_flag;
        logic alarm_pattern_flag;
        logic signal_absent_flag;
        logic far_loopback_flag;
    } lsi_live_s;

    // One-cycle event pulses from detectors outside this block.
    typedef struct packed {
        logic loop_up_code_event;
        logic loop_down_code_event;
        logic pattern_sync_event;
        logic tx_clock_missing_event;
        logic wave_amplitude_overflow_event;
        logic jitter_buffer_full_event;
        logic jitter_buffer_empty_event;
        logic pattern_bit_error_event;
        logic excess_zeros_event;
        logic code_violation_event;
        logic second_timer_event;
        logic error_counter_wrap_event;
    } lsi_evt_s;

endpackage : lsi_pkg

// ==== rtl/lsi_regs.sv ====
// Line status monitors and clear-on-read event latches behind AXI4-Lite.
// Assumes a synchronous active-low reset and detector pulses on aclk.
// Functional notes
// - Live bit 2 shows driver short.
// - Driver fault event on edge per select.
// - Live bit 1 shows alarm pattern.
// - Alarm event on edge per select.
// - Live bit 0 shows signal loss.
// - Signal loss event on edge per select.
// - Second live register bit 5 far loopback.
// - Live registers read-only at 17H, 18H.
// - Reading 19H returns then clears latches.
// - Reading 1AH returns then clears latches.
// - Latch A bit 6 loop-up code.
// - Latch A bit 5 loop-down code.
// - Latch A bit 4 pattern sync.
// - Latch A bit 3 transmit clock loss.
// - Latch A bit 2 driver fault.
// - Latch A bit 1 alarm pattern.
// - Latch A bit 0 signal loss.
// - Latch B bit 7 amplitude overflow.
// - Latch B bits 6,5 jitter buffer.
// - Latch B bits 4,3 errors, zeros.
// - Latch B bit 2 code violation.
// - Latch B bits 1,0 timer, counter.
`timescale 1ns/1ps
module lsi_regs
    import lsi_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Write address channel
    input  wire logic [LSI_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // Write data channel
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // Write response channel
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // Read address channel
    input  wire logic [LSI_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // Read data channel
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Line conditions and detector events
    input  wire lsi_live_s           live_in,
    input  wire lsi_evt_s            evt_in,
    // Interrupt request
    output logic                     irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Byte address of a register index.
    function automatic logic [LSI_AW-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = LSI_AW'({idx, 2'b00});
    endfunction : reg_addr

    // Edge-selected change detector shared by the three monitored flags.
    function automatic logic edge_hit(input logic now, input logic prev,
                                      input logic any_edge, input logic mask);
        edge_hit = !mask && (any_edge ? (now != prev) : (now && !prev));
    endfunction : edge_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]        live_a_r;
    logic [7:0]        live_b_r;
    logic [7:0]        live_a_nxt;
    logic [7:0]        live_b_nxt;
    logic [7:0]        latch_a_r;
    logic [7:0]        latch_b_r;
    logic [7:0]        set_a;
    logic [7:0]        set_b;
    logic [7:0]        ctrl_r;
    logic [LSI_AW-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_have_r;
    logic              w_have_r;
    logic              clr_a;
    logic              clr_b;
    logic              rd_take;
    logic [31:0]       rd_val;
    logic              rd_ok;

    // Live images; reserved bits stay zero.
    always_comb
    begin
        live_a_nxt = 8'h00;
        live_a_nxt[LSI_BIT_DF]  = live_in.driver_short_flag;
        live_a_nxt[LSI_BIT_AIS] = live_in.alarm_pattern_flag;
        live_a_nxt[LSI_BIT_LOS] = live_in.signal_absent_flag;
        live_b_nxt = 8'h00;
        live_b_nxt[LSI_BIT_RLP] = live_in.far_loopback_flag;
    end

    // Registered live status also serves as the previous value for edges.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            live_a_r <= 8'h00;
            live_b_r <= 8'h00;
        end
        else
        begin
            live_a_r <= live_a_nxt;
            live_b_r <= live_b_nxt;
        end
    end

    // Event set vectors in register layout.
    always_comb
    begin
        set_a = 8'h00;
        set_a[LSI_BIT_LPUP] = evt_in.loop_up_code_event;
        set_a[LSI_BIT_LPDN] = evt_in.loop_down_code_event;
        set_a[LSI_BIT_PRBS] = evt_in.pattern_sync_event;
        set_a[LSI_BIT_TCLK] = evt_in.tx_clock_missing_event;
        set_a[LSI_BIT_DF]   = edge_hit(live_a_nxt[LSI_BIT_DF], live_a_r[LSI_BIT_DF],
                              ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_DF],
                              ctrl_r[LSI_BIT_DF]);
        set_a[LSI_BIT_AIS]  = edge_hit(live_a_nxt[LSI_BIT_AIS], live_a_r[LSI_BIT_AIS],
                              ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_AIS],
                              ctrl_r[LSI_BIT_AIS]);
        set_a[LSI_BIT_LOS]  = edge_hit(live_a_nxt[LSI_BIT_LOS], live_a_r[LSI_BIT_LOS],
                              ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_LOS],
                              ctrl_r[LSI_BIT_LOS]);
        set_b = {evt_in.wave_amplitude_overflow_event,
                 evt_in.jitter_buffer_full_event,
                 evt_in.jitter_buffer_empty_event,
                 evt_in.pattern_bit_error_event,
                 evt_in.excess_zeros_event,
                 evt_in.code_violation_event,
                 evt_in.second_timer_event,
                 evt_in.error_counter_wrap_event};
    end

    // Sticky latches; a new event in the clearing cycle survives the clear.
    // Letting the set win means an event that races a read is never lost.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_a_r <= 8'h00;
            latch_b_r <= 8'h00;
        end
        else
        begin
            latch_a_r <= (clr_a ? 8'h00 : latch_a_r) | set_a;
            latch_b_r <= (clr_b ? 8'h00 : latch_b_r) | set_b;
        end
    end

    // Interrupt follows the latches one cycle later.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= (|latch_a_r) || (|latch_b_r);
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------

    // Address and data are caught independently in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end
        else if (aw_have_r && w_have_r)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
        end
    end

    // Ready is a flop so that every output leaves a register. It drops on the
    // accepting edge and returns when the response is taken, which keeps a
    // second write out until the first one has been answered.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
        end
    end

    // Only the control register is writable; status writes give SLVERR.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r       <= LSI_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= LSI_RESP_OKAY;
        end
        else if (aw_have_r && w_have_r)
        begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == reg_addr(LSI_IDX_CTRL))
            begin
                s_axi_bresp <= LSI_RESP_OKAY;
                if (wstrb_r[0])
                    ctrl_r <= wdata_r[7:0] & LSI_CTRL_WMASK;
            end
            else
                s_axi_bresp <= LSI_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------

    // Read decode; the clear strobes fire only on the accepted address.
    always_comb
    begin
        rd_take = s_axi_arvalid && s_axi_arready;
        rd_ok   = 1'b1;
        rd_val  = 32'h0000_0000;
        if (s_axi_araddr == reg_addr(LSI_IDX_LIVE_A))
            rd_val = {24'h00_0000, live_a_r};
        else if (s_axi_araddr == reg_addr(LSI_IDX_LIVE_B))
            rd_val = {24'h00_0000, live_b_r};
        else if (s_axi_araddr == reg_addr(LSI_IDX_LATCH_A))
            rd_val = {24'h00_0000, latch_a_r};
        else if (s_axi_araddr == reg_addr(LSI_IDX_LATCH_B))
            rd_val = {24'h00_0000, latch_b_r};
        else if (s_axi_araddr == reg_addr(LSI_IDX_CTRL))
            rd_val = {24'h00_0000, ctrl_r};
        else
            rd_ok = 1'b0;
        clr_a = rd_take && (s_axi_araddr == reg_addr(LSI_IDX_LATCH_A));
        clr_b = rd_take && (s_axi_araddr == reg_addr(LSI_IDX_LATCH_B));
    end

    // One read at a time; data is captured with the old latch value.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= LSI_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_ok ? LSI_RESP_OKAY : LSI_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A level that is low in one cycle and high in the next.
    sequence live_rise_s(sig);
        !sig ##1 sig;
    endsequence

    // A latch A read with no racing event, answered on the following cycle.
    sequence latch_a_read_s;
        clr_a && !(|set_a) ##1 s_axi_rvalid;
    endsequence

    // Level monitors show the line conditions one cycle late.
    live_df_a: assert property (
        ##1 live_a_r[LSI_BIT_DF] == $past(live_in.driver_short_flag))
        else $error("driver short live bit wrong");
    live_ais_a: assert property (
        ##1 live_a_r[LSI_BIT_AIS] == $past(live_in.alarm_pattern_flag))
        else $error("alarm live bit wrong");
    live_los_a: assert property (
        ##1 live_a_r[LSI_BIT_LOS] == $past(live_in.signal_absent_flag))
        else $error("signal loss live bit wrong");
    live_rlp_a: assert property (
        ##1 live_b_r == {2'b00, $past(live_in.far_loopback_flag), 5'h00})
        else $error("far loopback register wrong");

    // Edge-selected events on the three monitored conditions.
    df_rise_a: assert property (
        live_rise_s(live_in.driver_short_flag) ##0 !ctrl_r[LSI_BIT_DF]
        |=> latch_a_r[LSI_BIT_DF])
        else $error("driver rise not latched");
    short_fall_a: assert property (
        live_a_r[LSI_BIT_DF] && !live_in.driver_short_flag && !ctrl_r[LSI_BIT_DF] &&
        !ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_DF] && !clr_a && !latch_a_r[LSI_BIT_DF]
        |=> !latch_a_r[LSI_BIT_DF])
        else $error("driver fall latched with rising-only select");
    alarm_rise_a: assert property (
        live_rise_s(live_in.alarm_pattern_flag) ##0 !ctrl_r[LSI_BIT_AIS]
        |=> latch_a_r[LSI_BIT_AIS])
        else $error("alarm rise not latched");
    ais_fall_a: assert property (
        live_a_r[LSI_BIT_AIS] && !live_in.alarm_pattern_flag &&
        !ctrl_r[LSI_BIT_AIS] && ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_AIS]
        |=> latch_a_r[LSI_BIT_AIS])
        else $error("alarm fall not latched");
    loss_rise_a: assert property (
        live_rise_s(live_in.signal_absent_flag) ##0 !ctrl_r[LSI_BIT_LOS]
        |=> latch_a_r[LSI_BIT_LOS])
        else $error("signal loss rise not latched");
    loss_fall_a: assert property (
        live_a_r[LSI_BIT_LOS] && !live_in.signal_absent_flag &&
        !ctrl_r[LSI_BIT_LOS] && ctrl_r[LSI_CTRL_ES_SHIFT + LSI_BIT_LOS]
        |=> latch_a_r[LSI_BIT_LOS])
        else $error("signal loss fall not latched");
    los_mask_a: assert property (
        ctrl_r[LSI_BIT_LOS] && !clr_a && !latch_a_r[LSI_BIT_LOS]
        |=> !latch_a_r[LSI_BIT_LOS])
        else $error("masked signal loss latched");

    // Clear-on-read, read-only status and the interrupt level.
    clr_a_a: assert property (latch_a_read_s |-> latch_a_r == 8'h00)
        else $error("latch A not cleared by read");
    clr_b_a: assert property (clr_b |=> s_axi_rdata[7:0] == $past(latch_b_r))
        else $error("latch B read value wrong");
    clr_b_zero_a: assert property (clr_b && !(|set_b) |=> latch_b_r == 8'h00)
        else $error("latch B not cleared by read");
    ro_write_a: assert property (
        aw_have_r && w_have_r && awaddr_r != reg_addr(LSI_IDX_CTRL)
        |=> s_axi_bvalid && s_axi_bresp == LSI_RESP_SLVERR && $stable(ctrl_r))
        else $error("write to status register not refused");
    evt_b_a: assert property (|set_b |=> (latch_b_r & $past(set_b)) == $past(set_b))
        else $error("latch B event lost");
    irq_a: assert property (##1 irq == $past((|latch_a_r) || (|latch_b_r)))
        else $error("interrupt does not track latches");

endmodule : lsi_regs

// ==== test/lsi_host.sv ====
// Host model: an AXI4-Lite master standing where software reaches the block.
// Assumes the slave answers in its own time; only the bench watchdog ends a wait.
`timescale 1ns/1ps
module lsi_host
    import lsi_pkg::*;
(
    // Clock
    input  wire logic              aclk,
    // Write channels
    output logic [LSI_AW-1:0]      awaddr,
    output logic                   awvalid,
    input  wire logic              awready,
    output logic [31:0]            wdata,
    output logic [3:0]             wstrb,
    output logic                   wvalid,
    input  wire logic              wready,
    input  wire logic [1:0]        bresp,
    input  wire logic              bvalid,
    output logic                   bready,
    // Read channels
    output logic [LSI_AW-1:0]      araddr,
    output logic                   arvalid,
    input  wire logic              arready,
    input  wire logic [31:0]       rdata,
    input  wire logic [1:0]        rresp,
    input  wire logic              rvalid,
    output logic                   rready
);
    // Idle bus at time zero.
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // One write; address and data offered together, each dropped once taken.
    task automatic wr(input logic [LSI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    // One read; data and response are taken at the edge where rvalid is seen.
    task automatic rd(input logic [LSI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
endmodule : lsi_host

// ==== test/tb_top.sv ====
// Self-checking bench for the line status and event latch registers.
// Assumes the host model above is the only master on the register bus.
`timescale 1ns/1ps
module tb_top;
    import lsi_pkg::*;
    // ------------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------------
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [LSI_AW-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, irq;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    lsi_live_s         live_in = '0;
    lsi_evt_s          evt_in = '0;
    int                mismatches = 0;
    int                n_compared = 0;

    // A 40 ns period gives the 25 MHz bus clock.
    always #20 aclk = ~aclk;

    lsi_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .live_in(live_in), .evt_in(evt_in), .irq(irq));

    lsi_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Read a register and compare both data and response.
    task automatic rd_chk(input logic [LSI_AW-1:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        chk($sformatf("rdata@%h", a), d, exp);
        chk($sformatf("rresp@%h", a), {30'h0, r}, {30'h0, er});
    endtask : rd_chk

    task automatic wr_chk(input logic [LSI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, r);
        chk($sformatf("bresp@%h", a), {30'h0, r}, {30'h0, er});
    endtask : wr_chk

    // Live levels are applied at an edge, then given time to be sampled.
    task automatic set_live(input logic [3:0] v);
        @(posedge aclk);
        live_in <= lsi_live_s'(v);
        repeat (3) @(posedge aclk);
    endtask : set_live

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Latches and interrupt come out of reset clear.
    task automatic t_reset();
        rd_chk(12'h064, 32'h00, LSI_RESP_OKAY);
        rd_chk(12'h068, 32'h00, LSI_RESP_OKAY);
        chk("irq reset", {31'h0, irq}, 32'h0);
    endtask : t_reset

    // Live monitors follow the lines; masked changes must not latch anything.
    task automatic t_live();
        rd_chk(12'h05c, 32'h00, LSI_RESP_OKAY);
        set_live(4'hb);
        rd_chk(12'h05c, 32'h05, LSI_RESP_OKAY);
        rd_chk(12'h060, 32'h20, LSI_RESP_OKAY);
        wr_chk(12'h05c, 32'hff, LSI_RESP_SLVERR);
        set_live(4'h4);
        rd_chk(12'h05c, 32'h02, LSI_RESP_OKAY);
        rd_chk(12'h060, 32'h00, LSI_RESP_OKAY);
        rd_chk(12'h064, 32'h00, LSI_RESP_OKAY);
        rd_chk(12'h100, 32'h00, LSI_RESP_SLVERR);
        set_live(4'h0);
    endtask : t_live

    // Each detector pulse lands in its bit, raises irq, and a read clears both.
    task automatic t_events();
        logic [LSI_AW-1:0] a;
        int                b;
        for (int i = 11; i >= 0; i--)
        begin
            a = (i >= 8) ? 12'h064 : 12'h068;
            b = (i >= 8) ? i - 5 : i;
            @(posedge aclk);
            evt_in <= lsi_evt_s'(12'h001 << i);
            @(posedge aclk);
            evt_in <= '0;
            repeat (3) @(posedge aclk);
            chk("irq set", {31'h0, irq}, 32'h1);
            rd_chk(a, 32'h1 << b, LSI_RESP_OKAY);
            rd_chk(a, 32'h0, LSI_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("irq clear", {31'h0, irq}, 32'h0);
        end
    endtask : t_events

    // Rising-only and any-change selection for the three line conditions.
    task automatic t_edges();
        logic [3:0] on;
        for (int j = 0; j < 3; j++)
        begin
            on = 4'h2 << j;
            wr_chk(12'h080, 32'h00, LSI_RESP_OKAY);
            set_live(on);
            rd_chk(12'h064, 32'h1 << j, LSI_RESP_OKAY);
            set_live(4'h0);
            rd_chk(12'h064, 32'h0, LSI_RESP_OKAY);
            wr_chk(12'h080, 32'h10 << j, LSI_RESP_OKAY);
            set_live(on);
            rd_chk(12'h064, 32'h1 << j, LSI_RESP_OKAY);
            set_live(4'h0);
            rd_chk(12'h064, 32'h1 << j, LSI_RESP_OKAY);
            wr_chk(12'h080, 32'h07, LSI_RESP_OKAY);
        end
    endtask : t_edges

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // The tests need well under 2,000 cycles; allow 20,000.
    initial
    begin
        #800000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_live();
        t_events();
        t_edges();
        print_verdict();
    end
endmodule : tb_top
